//--- logic/agpc_pkg.sv
// Package: register map, field layout and reset values of the gain/power config bank
//
// Contract
// - Power mode is a two-bit field at bits 1:0 resetting to 10b; 00b very-low-power, 01b low-power, 1xb high-resolution.
// - Channel 3 gain is the three-bit field at bits 14:12, reset 000b, codes 0..7 giving gain 1 to 128 by doubling.
// - Channel 2 gain is the three-bit field at bits 10:8, reset 000b, same doubling map.
// - Channel 1 gain is the three-bit field at bits 6:4, reset 000b, same doubling map.
// - Channel 0 gain is the three-bit field at bits 2:0, reset 000b, same doubling map.
// - The gain register sits at index 4h, resets to 0000h, and the host writes zero into bits 15, 11, 7 and 3.
// - Index 5h is a fully reserved sixteen-bit register resetting to 0000h that the host only writes with zero.
// - The converter config register sits at index 6h, resets to 0600h, and holds chop delay, chop enable, detect fields.
// - The power mode field lives in the clock-config register at index 3h, which resets to 0F0Eh.
package agpc_pkg;
  // ==========================================================
  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_CLOCK_CONFIG = 4'h3;
  localparam logic [3:0] IDX_GAIN = 4'h4;
  localparam logic [3:0] IDX_RESERVED = 4'h5;
  localparam logic [3:0] IDX_CONV_CONFIG = 4'h6;
  localparam int ADDR_LSB = 2;
  localparam int REG_W = 16;
  // ==========================================================
  // Reset values
  localparam logic [15:0] RST_CLOCK_CONFIG = 16'h0f0e;
  localparam logic [15:0] RST_GAIN = 16'h0000;
  localparam logic [15:0] RST_RESERVED = 16'h0000;
  localparam logic [15:0] RST_CONV_CONFIG = 16'h0600;
  // ==========================================================
  // Writable masks; clock-config bits 15:12 always read zero
  localparam logic [15:0] WMASK_CLOCK_CONFIG = 16'h0fff;
  localparam logic [15:0] WMASK_FULL = 16'hffff;
  // ==========================================================
  // Field positions
  localparam int PWR_LSB = 0;
  localparam int CH0_GAIN_LSB = 0;
  localparam int CH1_GAIN_LSB = 4;
  localparam int CH2_GAIN_LSB = 8;
  localparam int CH3_GAIN_LSB = 12;
  localparam int GAIN_STRIDE = 4;
  localparam int CHOP_DLY_LSB = 9;
  localparam int CHOP_EN_BIT = 8;
  localparam int DET_ALL_BIT = 7;
  localparam int DET_NUM_LSB = 4;
  localparam int DET_LEN_LSB = 1;
  localparam int DET_EN_BIT = 0;
  // ==========================================================
  // Power modes, one-hot decoded
  typedef enum logic [2:0] {
    AGPC_PWR_VLP = 3'h1,
    AGPC_PWR_LP = 3'h2,
    AGPC_PWR_HR = 3'h4
  } agpc_pwr_t;
  localparam logic [1:0] PWR_CODE_VLP = 2'h0;
  localparam logic [1:0] PWR_CODE_LP = 2'h1;
endpackage

//--- logic/agpc_regs.sv
// APB register bank for power mode, channel gains, reserved word and converter config
`timescale 1ns/1ps
`default_nettype none
module agpc_regs #(
  parameter int NUM_CH = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [2:0] power_mode,
  output logic [8*NUM_CH-1:0] ch_gain_factor,
  output logic [3:0] chop_delay_select,
  output logic chop_enable,
  output logic detect_all_channels,
  output logic [2:0] detect_threshold_count,
  output logic [2:0] detect_measure_length,
  output logic current_detect_enable
);
  // Elaboration check: the gain register has room for exactly four channel fields
  if (NUM_CH != 4) begin : gen_bad_num_ch
    $error("agpc_regs supports exactly four channels");
  end

  // ==========================================================
  // Storage and decode
  logic [15:0] clock_config;
  logic [15:0] channel_gain_select;
  logic [15:0] reserved_word;
  logic [15:0] converter_config;
  logic wr_en;
  logic addr_ok;
  logic [3:0] idx;
  logic [15:0] wlane;

  // Byte enables on the two low lanes steer which halves update
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                        input logic [1:0] be, input logic [15:0] wm);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    merge = r & wm;
  endfunction

  // Gain code to linear factor: each step doubles
  function automatic logic [7:0] gain_of(input logic [2:0] code);
    gain_of = 8'h01 << code;
  endfunction

  localparam int ADDR_LSB_W = agpc_pkg::ADDR_LSB;
  assign idx = paddr[ADDR_LSB_W+3:ADDR_LSB_W];
  // Unmapped or misaligned access answers with an error, never stores
  assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[7:6] == 2'h0) &&
                   ((idx == agpc_pkg::IDX_CLOCK_CONFIG) || (idx == agpc_pkg::IDX_GAIN) ||
                    (idx == agpc_pkg::IDX_RESERVED) || (idx == agpc_pkg::IDX_CONV_CONFIG));
  assign wr_en = psel && penable && pwrite && addr_ok;
  assign wlane = pwdata[15:0];

  // ==========================================================
  // Register writes; the access phase is always one cycle, so a write lands at its only edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_config <= agpc_pkg::RST_CLOCK_CONFIG;
    end else if (wr_en && idx == agpc_pkg::IDX_CLOCK_CONFIG) begin
      clock_config <= merge(clock_config, wlane, pstrb[1:0], agpc_pkg::WMASK_CLOCK_CONFIG);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_gain_select <= agpc_pkg::RST_GAIN;
    end else if (wr_en && idx == agpc_pkg::IDX_GAIN) begin
      // Reserved bits are stored as written; the host keeps them zero
      channel_gain_select <= merge(channel_gain_select, wlane, pstrb[1:0],
                                   agpc_pkg::WMASK_FULL);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reserved_word <= agpc_pkg::RST_RESERVED;
    end else if (wr_en && idx == agpc_pkg::IDX_RESERVED) begin
      reserved_word <= merge(reserved_word, wlane, pstrb[1:0], agpc_pkg::WMASK_FULL);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_config <= agpc_pkg::RST_CONV_CONFIG;
    end else if (wr_en && idx == agpc_pkg::IDX_CONV_CONFIG) begin
      converter_config <= merge(converter_config, wlane, pstrb[1:0],
                                agpc_pkg::WMASK_FULL);
    end
  end

  // ==========================================================
  // Bus answer: registered read data, ready and error, no wait states
  logic [15:0] next_rd;
  always_comb begin
    case (idx)
      agpc_pkg::IDX_CLOCK_CONFIG: next_rd = clock_config;
      agpc_pkg::IDX_GAIN: next_rd = channel_gain_select;
      agpc_pkg::IDX_RESERVED: next_rd = reserved_word;
      agpc_pkg::IDX_CONV_CONFIG: next_rd = converter_config;
      default: next_rd = 16'h0000;
    endcase
  end

  // Ready is raised at the start of the access phase, one cycle after setup, so all outputs stay registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      pslverr <= !addr_ok;
      prdata <= (addr_ok && !pwrite) ? {16'h0000, next_rd} : 32'h0000_0000;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // Decoded controls; registered so every output comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_mode <= agpc_pkg::AGPC_PWR_HR;
    end else begin
      case (clock_config[agpc_pkg::PWR_LSB +: 2])
        agpc_pkg::PWR_CODE_VLP: power_mode <= agpc_pkg::AGPC_PWR_VLP;
        agpc_pkg::PWR_CODE_LP: power_mode <= agpc_pkg::AGPC_PWR_LP;
        default: power_mode <= agpc_pkg::AGPC_PWR_HR;
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g = g + 1) begin : gen_gain
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ch_gain_factor[8*g +: 8] <= 8'h01 << agpc_pkg::RST_GAIN[agpc_pkg::GAIN_STRIDE*g +: 3];
        end else begin
          ch_gain_factor[8*g +: 8] <= gain_of(channel_gain_select[agpc_pkg::GAIN_STRIDE*g +: 3]);
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Reset copies come from the register's own reset word so the two never disagree
      chop_delay_select <= agpc_pkg::RST_CONV_CONFIG[agpc_pkg::CHOP_DLY_LSB +: 4];
      chop_enable <= agpc_pkg::RST_CONV_CONFIG[agpc_pkg::CHOP_EN_BIT];
      detect_all_channels <= agpc_pkg::RST_CONV_CONFIG[agpc_pkg::DET_ALL_BIT];
      detect_threshold_count <= agpc_pkg::RST_CONV_CONFIG[agpc_pkg::DET_NUM_LSB +: 3];
      detect_measure_length <= agpc_pkg::RST_CONV_CONFIG[agpc_pkg::DET_LEN_LSB +: 3];
      current_detect_enable <= agpc_pkg::RST_CONV_CONFIG[agpc_pkg::DET_EN_BIT];
    end else begin
      chop_delay_select <= converter_config[agpc_pkg::CHOP_DLY_LSB +: 4];
      chop_enable <= converter_config[agpc_pkg::CHOP_EN_BIT];
      detect_all_channels <= converter_config[agpc_pkg::DET_ALL_BIT];
      detect_threshold_count <= converter_config[agpc_pkg::DET_NUM_LSB +: 3];
      detect_measure_length <= converter_config[agpc_pkg::DET_LEN_LSB +: 3];
      current_detect_enable <= converter_config[agpc_pkg::DET_EN_BIT];
    end
  end

  // ==========================================================
  // Checks
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    pready;
  endsequence

  AST_READY_NEXT: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup |=> s_answer) else $error("ready not one cycle after setup");
  AST_PWR_VLP: assert property (@(posedge pclk) disable iff (!presetn)
    clock_config[1:0] == 2'h0 |=> power_mode == 3'h1) else $error("bad vlp decode");
  AST_PWR_HR: assert property (@(posedge pclk) disable iff (!presetn)
    clock_config[1] |=> power_mode == 3'h4) else $error("bad hr decode");
  AST_CH3_GAIN: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> ch_gain_factor[31:24] == (8'h01 << $past(channel_gain_select[14:12])))
    else $error("ch3 gain mismatch");
  AST_CH2_GAIN: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> ch_gain_factor[23:16] == (8'h01 << $past(channel_gain_select[10:8])))
    else $error("ch2 gain mismatch");
  AST_CH1_GAIN: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> ch_gain_factor[15:8] == (8'h01 << $past(channel_gain_select[6:4])))
    else $error("ch1 gain mismatch");
  AST_CH0_GAIN: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> ch_gain_factor[7:0] == (8'h01 << $past(channel_gain_select[2:0])))
    else $error("ch0 gain mismatch");
  AST_GAIN_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && idx == 4'h4 && pstrb[1:0] == 2'h3) |=> channel_gain_select == $past(pwdata[15:0]))
    else $error("gain write lost");
  AST_RSVD_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_en && idx == 4'h5) |=> $stable(reserved_word)) else $error("reserved changed");
  AST_CLK_TOP_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    clock_config[15:12] == 4'h0) else $error("clock config top bits set");
  AST_CHOP: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> chop_delay_select == $past(converter_config[12:9])) else $error("chop delay");
endmodule
`default_nettype wire

//--- test/agpc_apb_host.sv
// APB host model that issues single register transfers to the bank
`timescale 1ns/1ps
`default_nettype none
module agpc_apb_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic pready
);
  // ==========================================================
  // Idle bus from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
  end

  // ==========================================================
  // One transfer; waits an edge first so a release and the next setup never share a step
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic ok);
    int n;
    ok = 1'b0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // Request held until pready is sampled high; bounded so a dead slave cannot hang us
    for (n = 0; n < 16 && !ok; n++) begin
      @(posedge pclk);
      ok = (pready === 1'b1);
    end
    // Released address and data lines show inverted values so stale data is never taken as live
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

//--- test/adc_gain_power_config_regs_test.sv
// Self-checking bench for the gain, power and converter config register bank
`timescale 1ns/1ps
`default_nettype none
module adc_gain_power_config_regs_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, chop_enable, det_all, det_en;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, ch_gain_factor, g;
  logic [3:0] pstrb, chop_dly;
  logic [2:0] power_mode, det_num, det_len;
  logic [15:0] cc, gn, cf;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  logic [31:0] d;
  logic [7:0] bad_a [4] = '{8'h00, 8'h1c, 8'h19, 8'h58};
  int n_errors = 0, checked = 0, seed = 37240;

  // ==========================================================
  // Clock, design and host model
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  agpc_regs #(.NUM_CH(4)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .power_mode(power_mode),
    .ch_gain_factor(ch_gain_factor), .chop_delay_select(chop_dly), .chop_enable(chop_enable),
    .detect_all_channels(det_all), .detect_threshold_count(det_num),
    .detect_measure_length(det_len), .current_detect_enable(det_en));
  agpc_apb_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready));

  // ==========================================================
  // Comparison, verdict and bus access with its noted answer
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d of %0d comparisons", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     input logic [3:0] s, input logic err, input logic [15:0] rd);
    logic ok;
    exp_q.push_back({err, 16'h0000, rd});
    host.xfer(wr, a, wd, s, ok);
    if (!ok) begin
      n_errors++;
      complete_run();
    end
  endtask
  // Decoded outputs lag the register by a clock, so look two edges on, mid-cycle
  task automatic chk_out();
    int k;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    for (k = 0; k < 4; k++) g[8*k+:8] = 8'h01 << gn[4*k+:3];
    check("power_mode", power_mode, cc[1:0] == 2'h0 ? 3'h1 : cc[1:0] == 2'h1 ? 3'h2 : 3'h4);
    check("gains", ch_gain_factor, g);
    check("cfg_fields", {chop_dly, chop_enable, det_all, det_num, det_len, det_en}, cf[12:0]);
  endtask
  task automatic rd_all();
    acc(1'b0, 8'h0c, 32'h0, 4'h0, 1'b0, cc);
    acc(1'b0, 8'h10, 32'h0, 4'h0, 1'b0, gn);
    acc(1'b0, 8'h14, 32'h0, 4'h0, 1'b0, 16'h0000);
    acc(1'b0, 8'h18, 32'h0, 4'h0, 1'b0, cf);
    chk_out();
  endtask

  // ==========================================================
  // Watcher: every answer is matched against the oldest note
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      if (exp_q.size() == 0) check("orphan_answer", 32'h1, 32'h0);
      else begin
        e = exp_q.pop_front();
        check("prdata", prdata, e[31:0]);
        check("pslverr", pslverr, e[32]);
      end
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    presetn = 1'b0;
    cc = 16'h0f0e;
    gn = 16'h0000;
    cf = 16'h0600;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd_all();
    // Every power code; bits 15:12 carry random data and must read zero
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      cc = {d[15:8], 2'b00, d[5:2], 2'(i)} & 16'h0fff;
      acc(1'b1, 8'h0c, {16'h0, d[15:8], 2'b00, d[5:2], 2'(i)}, 4'hf, 1'b0, 16'h0);
      rd_all();
    end
    // Every gain code on every channel, reserved bits kept zero by the host
    for (int i = 0; i < 8; i++) begin
      gn = {1'b0, 3'(i), 1'b0, 3'(i + 1), 1'b0, 3'(i + 3), 1'b0, 3'(i + 6)};
      acc(1'b1, 8'h10, {16'h0, gn}, 4'hf, 1'b0, 16'h0);
      rd_all();
    end
    // Converter config, full then upper lane only
    repeat (3) begin
      d = $random(seed) & 32'h0000_1fff;
      cf = d[15:0];
      acc(1'b1, 8'h18, d, 4'hf, 1'b0, 16'h0);
      rd_all();
    end
    d = $random(seed) & 32'h0000_1fff;
    cf[15:8] = d[15:8];
    acc(1'b1, 8'h18, d, 4'h2, 1'b0, 16'h0);
    acc(1'b1, 8'h14, 32'h0, 4'hf, 1'b0, 16'h0);
    // Unmapped and misaligned places refuse and store nothing
    foreach (bad_a[j]) begin
      acc(1'b1, bad_a[j], 32'h0000_ffff, 4'hf, 1'b1, 16'h0);
      acc(1'b0, bad_a[j], 32'h0, 4'h0, 1'b1, 16'h0);
    end
    rd_all();
    // Second reset in mid-run brings back every reset value
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    cc = 16'h0f0e;
    gn = 16'h0000;
    cf = 16'h0600;
    rd_all();
    check("notes_left", exp_q.size(), 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
